// ==== shared/fsb_pkg.sv ====
// package: command codes, status fields and timing for the flash status controller
package fsb_pkg;
   // command codes written on the low data byte
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   localparam logic [7:0] CMD_BUF_SETUP    = 8'he8;
   localparam logic [7:0] CMD_PIN_CFG      = 8'hb8;
   localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
   localparam logic [7:0] CMD_LOCK_SET     = 8'h01;
   localparam logic [7:0] CMD_LOCK_CLEAR   = 8'hd0;
   // operation_status field positions
   localparam int SR_READY_BIT      = 7;
   localparam int SR_ERASE_SUSP_BIT = 6;
   localparam int SR_ERASE_ERR_BIT  = 5;
   localparam int SR_PROG_ERR_BIT   = 4;
   localparam int SR_SUPPLY_BIT     = 3;
   localparam int SR_PROG_SUSP_BIT  = 2;
   localparam int SR_LOCKED_BIT     = 1;
   localparam logic [15:0] SR_VALID_MASK = 16'h00fe;
   localparam int XSR_BUF_AVAIL_BIT = 7;
   localparam int LOCK_DATA_BIT     = 0;
   localparam logic [22:0] LOCK_CFG_OFFSET = 23'h000002;
   localparam logic [1:0] CFG_CODE_RESET = 2'h0;
   // ready-pin modes
   localparam logic [1:0] CC_LEVEL       = 2'h0;
   localparam logic [1:0] CC_PULSE_ERASE = 2'h1;
   localparam logic [1:0] CC_PULSE_PROG  = 2'h2;
   localparam logic [1:0] CC_PULSE_ANY   = 2'h3;
   // bus timing at 100 ns per cycle
   localparam int CLK_NS        = 100;
   localparam int WE_LOW_NS     = 70;
   localparam int WE_HIGH_NS    = 30;
   localparam int READ_ACC_NS   = 120;
   localparam int PULSE_TYP_NS  = 250;
   localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_HIGH_CYC   = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_ACC_CYC  = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_MIN_CYC = (PULSE_TYP_NS / 2 + CLK_NS - 1) / CLK_NS;
endpackage

// ==== rtl/fsb_host.sv ====
// host controller that issues status, lock and ready-pin commands to the flash
//
// Behaviour
// - bits 6..1 are meaningless until bit 7 reads 1; host waits for ready
// - host masks status bits 15..8 and bit 0
// - buffer setup accepted when extended bit 7 is 1; else host retries
// - pin configuration is per bank; host writes only the bank given with the request
// - pin configuration is setup command then code in a second write
// - read-status command, then the next read returns status
`timescale 1ns/1ps
`default_nettype none
module fsb_host #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 16
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // user command port
   input  wire logic              req,
   input  wire logic [2:0]        op,
   input  wire logic              bank,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [1:0]        cfg_code,
   output logic                   busy,
   output logic                   done,
   output logic [DATA_W-1:0]      result,
   output logic                   error,
   output logic                   pin_event,
   // flash pins
   output logic                   ce_n,
   output logic                   oe_n,
   output logic                   we_n,
   output logic                   bank_select,
   output logic [ADDR_W-1:0]      a,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe_n,
   input  wire logic [DATA_W-1:0] dq_in,
   input  wire logic              ready_busy_output
);
   // op codes of the user port
   localparam logic [2:0] OP_STATUS = 3'h0;
   localparam logic [2:0] OP_CLEAR  = 3'h1;
   localparam logic [2:0] OP_LOCK   = 3'h2;
   localparam logic [2:0] OP_UNLOCK = 3'h3;
   localparam logic [2:0] OP_QLOCK  = 3'h4;
   localparam logic [2:0] OP_BUF    = 3'h5;
   localparam logic [2:0] OP_CFG    = 3'h6;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_WLOW = 7'h02,
      S_WHI  = 7'h04,
      S_RLOW = 7'h08,
      S_POLL = 7'h10,
      S_DONE = 7'h20,
      S_NEXT = 7'h40
   } fsb_state_t;

   fsb_state_t       state;
   logic [2:0]       cur_op;
   logic [1:0]       step;
   logic [3:0]       cnt;
   logic [7:0]       wdata;
   logic [DATA_W-1:0] dq_s1, dq_s2;
   logic             rb_s1, rb_s2, rb_prev;
   logic [3:0]       low_cnt;

   // pins cross two flops before use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1 <= '0;
         dq_s2 <= '0;
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
      end else begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         rb_s1 <= ready_busy_output;
         rb_s2 <= rb_s1;
      end
   end

   // low pulse on the pin marks a completion; short glitches ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rb_prev   <= 1'b1;
         low_cnt   <= '0;
         pin_event <= 1'b0;
      end else begin
         rb_prev   <= rb_s2;
         pin_event <= 1'b0;
         if (!rb_s2 && low_cnt != 4'hf) low_cnt <= low_cnt + 4'h1;
         if (rb_s2 && !rb_prev && low_cnt >= 4'(fsb_pkg::PULSE_MIN_CYC)) pin_event <= 1'b1;
         if (rb_s2) low_cnt <= '0;
      end
   end

   // command word for each step of each sequence
   always_comb begin
      wdata = fsb_pkg::CMD_READ_STATUS;
      unique case (cur_op)
         OP_CLEAR:  wdata = fsb_pkg::CMD_CLEAR_STATUS;
         OP_LOCK:   wdata = step == 2'h0 ? fsb_pkg::CMD_LOCK_SETUP : fsb_pkg::CMD_LOCK_SET;
         OP_UNLOCK: wdata = step == 2'h0 ? fsb_pkg::CMD_LOCK_SETUP : fsb_pkg::CMD_LOCK_CLEAR;
         OP_QLOCK:  wdata = fsb_pkg::CMD_READ_ID;
         OP_BUF:    wdata = step == 2'h0 ? fsb_pkg::CMD_BUF_SETUP : fsb_pkg::CMD_READ_ARRAY;
         OP_CFG:    wdata = step == 2'h0 ? fsb_pkg::CMD_PIN_CFG : {6'h00, cfg_code};
         default:   wdata = fsb_pkg::CMD_READ_STATUS;
      endcase
   end

   // writes per op: lock, unlock and config take two writes
   function automatic logic [1:0] fsb_writes(input logic [2:0] o);
      if (o == OP_LOCK || o == OP_UNLOCK || o == OP_CFG) return 2'h2;
      return 2'h1;
   endfunction

   // main sequencer; inputs held stable by the user while busy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= S_IDLE;
         cur_op      <= OP_STATUS;
         step        <= '0;
         cnt         <= '0;
         ce_n        <= 1'b1;
         oe_n        <= 1'b1;
         we_n        <= 1'b1;
         bank_select <= 1'b0;
         a           <= '0;
         dq_out      <= '0;
         dq_oe_n     <= 1'b1;
         busy        <= 1'b0;
         done        <= 1'b0;
         result      <= '0;
         error       <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state)
            S_IDLE: begin
               if (req) begin
                  cur_op      <= op;
                  step        <= '0;
                  busy        <= 1'b1;
                  bank_select <= bank; // one bank per request
                  a           <= addr;
                  state       <= S_NEXT;
               end
            end
            S_NEXT: begin
               // bank and address settle before the strobe
               dq_out  <= {{(DATA_W-8){1'b0}}, wdata};
               dq_oe_n <= 1'b0;
               ce_n    <= 1'b0;
               we_n    <= 1'b0;
               cnt     <= 4'(fsb_pkg::WE_LOW_CYC);
               state   <= S_WLOW;
            end
            S_WLOW: begin
               if (cnt == 4'h1) begin
                  we_n  <= 1'b1;
                  ce_n  <= 1'b1;
                  cnt   <= 4'(fsb_pkg::WE_HIGH_CYC);
                  state <= S_WHI;
               end else cnt <= cnt - 4'h1;
            end
            S_WHI: begin
               if (cnt == 4'h1) begin
                  dq_oe_n <= 1'b1;
                  if (step + 2'h1 < fsb_writes(cur_op)) begin
                     step  <= step + 2'h1;
                     state <= S_NEXT;
                  end else if (cur_op == OP_CLEAR || cur_op == OP_CFG) begin
                     state <= S_DONE;
                  end else begin
                     if (cur_op == OP_QLOCK) a <= addr + ADDR_W'(fsb_pkg::LOCK_CFG_OFFSET);
                     ce_n  <= 1'b0;
                     oe_n  <= 1'b0;
                     cnt   <= 4'(fsb_pkg::READ_ACC_CYC + 2);
                     state <= S_RLOW;
                  end
               end else cnt <= cnt - 4'h1;
            end
            S_RLOW: begin
               // extra two cycles cover the input synchroniser
               if (cnt == 4'h1) begin
                  oe_n  <= 1'b1;
                  ce_n  <= 1'b1;
                  state <= S_POLL;
               end else cnt <= cnt - 4'h1;
            end
            S_POLL: begin
               unique case (cur_op)
                  OP_QLOCK: begin
                     result <= {{(DATA_W-1){1'b0}}, dq_s2[fsb_pkg::LOCK_DATA_BIT]};
                     error  <= 1'b0;
                     state  <= S_DONE;
                  end
                  OP_BUF: begin
                     if (dq_s2[fsb_pkg::XSR_BUF_AVAIL_BIT]) begin
                        result <= dq_s2;
                        error  <= 1'b0;
                        state  <= S_DONE;
                     end else begin
                        step  <= '0;
                        state <= S_NEXT; // retry setup until accepted
                     end
                  end
                  default: begin
                     if (!dq_s2[fsb_pkg::SR_READY_BIT]) begin
                        step  <= fsb_writes(cur_op) - 2'h1;
                        state <= S_NEXT; // reissue read-status and poll again
                        if (cur_op != OP_STATUS) cur_op <= OP_STATUS;
                     end else begin
                        result <= dq_s2 & fsb_pkg::SR_VALID_MASK;
                        // bits 5,4,3,1 are the sticky error flags
                        error  <= dq_s2[fsb_pkg::SR_ERASE_ERR_BIT] | dq_s2[fsb_pkg::SR_PROG_ERR_BIT] |
                                  dq_s2[fsb_pkg::SR_SUPPLY_BIT] | dq_s2[fsb_pkg::SR_LOCKED_BIT];
                        state  <= S_DONE;
                     end
                  end
               endcase
            end
            S_DONE: begin
               busy  <= 1'b0;
               done  <= 1'b1;
               state <= S_IDLE;
            end
         endcase
      end
   end

   // strobes never overlap: read and write are exclusive
   no_overlap_a: assert property (@(posedge clk) disable iff (!rst_n) !(!oe_n && !we_n))
      else $error("oe_n and we_n low together");
   status_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
      done && (cur_op == OP_STATUS) |-> (result & ~fsb_pkg::SR_VALID_MASK) == 16'h0000)
      else $error("reserved status bits not masked");
   ready_first_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == S_POLL && cur_op == OP_STATUS && !dq_s2[fsb_pkg::SR_READY_BIT] |=> state == S_NEXT)
      else $error("status taken while busy");
   buf_retry_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == S_POLL && cur_op == OP_BUF && !dq_s2[fsb_pkg::XSR_BUF_AVAIL_BIT] |=>
      state == S_NEXT ##1 dq_out[7:0] == fsb_pkg::CMD_BUF_SETUP)
      else $error("buffer setup not reissued");
   sequence cfg_first_s;
      state == S_NEXT && cur_op == OP_CFG && step == 2'h0;
   endsequence
   cfg_two_writes_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_first_s |=> dq_out[7:0] == fsb_pkg::CMD_PIN_CFG ##[1:6] (state == S_WLOW && step == 2'h1))
      else $error("config code write missing");
   we_width_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(we_n) |-> (!ce_n && !dq_oe_n) ##1 (we_n && !dq_oe_n))
      else $error("write strobe without enable or data hold");
   done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) done |=> !done && !busy)
      else $error("done not single pulse");
   pulse_event_a: assert property (@(posedge clk) disable iff (!rst_n)
      pin_event |-> $past(rb_s2, 2) == 1'b0 && rb_prev)
      else $error("pin event without low pulse");
endmodule
`default_nettype wire

// ==== tb/fsb_flash_model.sv ====
// behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module fsb_flash_model #(
   parameter int BUSY_CYC  = 6,
   parameter int PULSE_CYC = 3
) (
   // sampling clock and device pins
   input  wire logic        clk,
   input  wire logic        dev_rst_n,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        bank_select,
   input  wire logic [22:0] a,
   input  wire logic [15:0] dq_out,
   output logic      [15:0] dq_in,
   output logic             rb_oe_n,
   // test knobs
   input  wire logic        supply_low,
   input  wire logic        buf_free
);
   logic        lock [2][128] = '{default: 1'b0}; // kept over device reset
   logic [1:0]  cfg [2];
   logic [6:1]  sr;
   logic [7:0]  pend;
   logic [15:0] last = 16'h0;
   logic [15:0] wd;
   logic [22:0] wa;
   logic        wb;
   logic        wr;
   logic        ob;
   logic        kind;
   int          mode;
   int          busy_cnt;
   int          pulse_cnt;
   wire         rd  = !ce_n && !oe_n;
   wire         rdy = busy_cnt == 0;
   // reserved bits read as ones so that host masking matters; bits 6..1 junk while busy
   wire [15:0]  data = mode == 1 ? {8'hff, rdy, rdy ? sr : 6'h3f, 1'b1} :
                       mode == 3 ? {8'hff, buf_free, 7'h7f} :
                       {15'h0, a[15:0] == 16'h2 && lock[bank_select][a[22:16]]};
   assign dq_in   = rd ? data : ~last;
   assign rb_oe_n = !((cfg[ob] == 2'h0 && !rdy) || pulse_cnt > 0);
   always @(posedge clk) if (rd) last <= data;
   // acts on the falling edge so the host always samples settled pins
   always @(negedge clk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         cfg[0]    <= 2'h0;
         cfg[1]    <= 2'h0;
         sr        <= 6'h0;
         pend      <= 8'h0;
         mode      <= 0;
         busy_cnt  <= 0;
         pulse_cnt <= 0;
         wr        <= 1'b0;
         ob        <= 1'b0;
         kind      <= 1'b0;
      end else begin
         wr <= !we_n && !ce_n;
         if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
            // clear-lock counts as erase, set-lock as program completion
            if (busy_cnt == 1 && (cfg[ob] == 2'h3 || cfg[ob] == (kind ? 2'h2 : 2'h1))) pulse_cnt <= PULSE_CYC;
         end else if (pulse_cnt > 0) pulse_cnt <= pulse_cnt - 1;
         if (!we_n && !ce_n) begin
            wd <= dq_out;
            wa <= a;
            wb <= bank_select;
         end else if (wr) begin
            if (pend == 8'h60) begin
               pend     <= 8'h0;
               ob       <= wb;
               kind     <= wd[7:0] == 8'h01;
               mode     <= 1;
               busy_cnt <= BUSY_CYC;
               if (supply_low) begin
                  sr[3] <= 1'b1;
                  if (wd[7:0] == 8'h01) sr[4] <= 1'b1;
                  else sr[5] <= 1'b1;
               end else if (wd[7:0] == 8'h01) lock[wb][wa[22:16]] <= 1'b1;
               else if (wd[7:0] == 8'hd0) begin
                  for (int i = 0; i < 128; i++) lock[wb][i] <= 1'b0;
               end else sr[5:4] <= 2'h3;
            end else if (pend == 8'hb8) begin
               pend    <= 8'h0;
               cfg[wb] <= wd[1:0];
            end else case (wd[7:0])
               8'h70: mode <= 1;
               8'h50: sr <= 6'h0;
               8'h90: mode <= 2;
               8'he8: mode <= 3;
               default: pend <= wd[7:0];
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [22:0] B1 = 23'h010000;
   localparam logic [22:0] B2 = 23'h020000;
   localparam logic [22:0] B5 = 23'h050000;
   logic        clk = 1'b0, rst_n = 1'b0, dev_rst_n = 1'b0, req = 1'b0, bank = 1'b0;
   logic [2:0]  op = 3'h0;
   logic [22:0] addr = 23'h0;
   logic [1:0]  cfg_code = 2'h0;
   logic        supply_low = 1'b0, buf_free = 1'b0;
   logic        busy, done, error, pin_event, ce_n, oe_n, we_n, bank_select, dq_oe_n, rb_oe_n;
   logic [15:0] result, dq_out, dq_in;
   logic [22:0] a;
   int          errors = 0, n_compared = 0, events = 0, cycles = 0, e0;
   wire         ready_busy_output = rb_oe_n; // pull-up when released
   always #50 clk = ~clk;
   fsb_host fsb_host_inst (.clk(clk), .rst_n(rst_n), .req(req), .op(op), .bank(bank), .addr(addr),
      .cfg_code(cfg_code), .busy(busy), .done(done), .result(result), .error(error), .pin_event(pin_event),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .bank_select(bank_select), .a(a), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .dq_in(dq_in), .ready_busy_output(ready_busy_output));
   fsb_flash_model fsb_flash_model_inst (.clk(clk), .dev_rst_n(dev_rst_n), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .bank_select(bank_select), .a(a), .dq_out(dq_oe_n ? 16'hffff : dq_out), .dq_in(dq_in),
      .rb_oe_n(rb_oe_n),
      .supply_low(supply_low), .buf_free(buf_free));
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (pin_event === 1'b1) events++;
      if (cycles == 20000) begin
         errors++;
         $display("[FAIL] %0t run hung", $time);
         conclude();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask
   // operands stay put until the next request, as the port expects
   task automatic issue(input logic [2:0] o, input logic b, input logic [22:0] ad, input logic [1:0] c);
      @(posedge clk);
      #1;
      op = o;
      bank = b;
      addr = ad;
      cfg_code = c;
      req = 1'b1;
      @(posedge clk);
      #1;
      req = 1'b0;
   endtask
   task automatic finish_op();
      int n;
      for (n = 0; n < 400 && done !== 1'b1; n++) @(posedge clk) #1;
      if (done !== 1'b1) check(16'h0, 16'h1, "no done");
   endtask
   task automatic run(input logic [2:0] o, input logic b, input logic [22:0] ad, input logic [1:0] c);
      issue(o, b, ad, c);
      finish_op();
   endtask
   task automatic pinop(input logic [2:0] o, input logic b, input logic [15:0] exp, input string what);
      e0 = events;
      run(o, b, B5, 2'h0);
      repeat (4) @(posedge clk);
      #1;
      check(16'(events - e0), exp, what);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      dev_rst_n = 1'b1;
      run(3'h0, 1'b0, B1, 2'h0);
      check(result, 16'h0080, "idle status");
      check({15'h0, error}, 16'h0, "idle error");
      $display("test reset_status done");
      run(3'h4, 1'b0, B1, 2'h0);
      check(result, 16'h0000, "unlocked");
      run(3'h2, 1'b0, B1, 2'h0);
      check(result, 16'h0080, "set lock ok");
      run(3'h4, 1'b0, B1, 2'h0);
      check(result, 16'h0001, "locked");
      run(3'h4, 1'b1, B1, 2'h0);
      check(result, 16'h0000, "other bank");
      run(3'h3, 1'b0, B1, 2'h0);
      run(3'h4, 1'b0, B1, 2'h0);
      check(result, 16'h0000, "bank unlocked");
      $display("test lock done");
      supply_low = 1'b1;
      run(3'h2, 1'b0, B2, 2'h0);
      check(result, 16'h0098, "set on low supply");
      check({15'h0, error}, 16'h1, "error flag");
      run(3'h3, 1'b0, B2, 2'h0);
      check(result, 16'h00b8, "errors pile up");
      supply_low = 1'b0;
      run(3'h0, 1'b0, B2, 2'h0);
      check(result, 16'h00b8, "status keeps errors");
      run(3'h4, 1'b0, B2, 2'h0);
      check(result, 16'h0000, "aborted lock");
      run(3'h1, 1'b0, B2, 2'h0);
      run(3'h0, 1'b0, B2, 2'h0);
      check(result, 16'h0080, "cleared");
      $display("test errors done");
      // a refused setup keeps the host busy reissuing it
      issue(3'h5, 1'b0, B1, 2'h0);
      repeat (60) @(posedge clk);
      #1;
      check({15'h0, busy}, 16'h1, "buffer refused");
      buf_free = 1'b1;
      finish_op();
      check(result & 16'h0080, 16'h0080, "buffer retried");
      run(3'h5, 1'b0, B1, 2'h0);
      check(result & 16'h0080, 16'h0080, "buffer granted");
      $display("test buffer done");
      for (int c = 0; c < 4; c++) begin
         run(3'h6, 1'b0, B5, 2'(c));
         pinop(3'h2, 1'b0, 16'(c != 1), "program pin");
         pinop(3'h3, 1'b0, 16'(c != 2), "erase pin");
      end
      run(3'h6, 1'b0, B5, 2'h1);
      pinop(3'h2, 1'b1, 16'h1, "bank1 level");
      pinop(3'h2, 1'b0, 16'h0, "bank0 pulse");
      $display("test pin done");
      dev_rst_n = 1'b0;
      @(posedge clk);
      #1;
      dev_rst_n = 1'b1;
      pinop(3'h2, 1'b0, 16'h1, "level after reset");
      run(3'h4, 1'b1, B5, 2'h0);
      check(result, 16'h0001, "lock kept");
      $display("test device_reset done");
      conclude();
   end
endmodule
`default_nettype wire
